// >>> bench/vms_host_model.sv
// Host stand-in issuing register commands
`timescale 1ns/10ps
`default_nettype none
module vms_host_model
(
  input wire logic clk,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code
);
  initial
  begin
    cmd_valid = 1'h0;
    cmd_write = 1'h0;
    cmd_code = 8'h00;
  end
  // Code goes inverted when idle, never left at the last value
  task automatic xfer(input logic w, input logic [7:0] c, output logic v, output logic [7:0] d);
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_write <= w;
    cmd_code <= c;
    @(posedge clk);
    cmd_valid <= 1'h0;
    cmd_code <= ~c;
    @(posedge clk);
    v = rd_valid;
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// >>> bench/vms_status_regs_monitor.sv
// Checker for the status flag registers
`timescale 1ns/10ps
`default_nettype none
module vms_monitor
  import vms_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic io_supply_over_fault,
  input wire logic ext_monitor_one_enable,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [7:0] supply_overvoltage_status,
  input wire logic [7:0] external_monitor_status,
  input wire logic input_supply_over_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic rs = cmd_valid && !cmd_write && cmd_code == VMS_CMD_RD_SUPPLY_OV;
  property p_rst; $rose(resetn) |-> supply_overvoltage_status == 8'h00 && external_monitor_status == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("flags not clear after reset");
  property p_set; io_supply_over_fault [*4] |-> supply_overvoltage_status[7]; endproperty
  a_set: assert property (p_set) else $error("fault did not set flag");
  property p_clr; !io_supply_over_fault [*4] ##0 rs |=> !supply_overvoltage_status[7]; endproperty
  a_clr: assert property (p_clr) else $error("read left stale flag");
  property p_hold; !rs |=> (supply_overvoltage_status & $past(supply_overvoltage_status)) == $past(supply_overvoltage_status); endproperty
  a_hold: assert property (p_hold) else $error("flag lost without read");
  property p_rdv; rs |=> rd_valid && rd_data == $past(supply_overvoltage_status); endproperty
  a_rdv: assert property (p_rdv) else $error("read answer wrong");
  property p_wr; cmd_valid && cmd_write |=> !rd_valid; endproperty
  a_wr: assert property (p_wr) else $error("write answered");
  property p_mask; !ext_monitor_one_enable && external_monitor_status[1:0] == 2'h0 |=> external_monitor_status[1:0] == 2'h0; endproperty
  a_mask: assert property (p_mask) else $error("disabled monitor set flag");
  property p_rsv; (supply_overvoltage_status & ~VMS_SUPPLY_OV_MASK) == 8'h00 && (external_monitor_status & ~VMS_EXT_MON_MASK) == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_mir; input_supply_over_flag == supply_overvoltage_status[VMS_INPUT_SUPPLY_OV_BIT]; endproperty
  a_mir: assert property (p_mir) else $error("input flag copy differs");
endmodule
bind vms_status_regs vms_monitor i_mon (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
  .cmd_code(cmd_code), .io_supply_over_fault(io_supply_over_fault), .ext_monitor_one_enable(ext_monitor_one_enable),
  .rd_data(rd_data), .rd_valid(rd_valid), .supply_overvoltage_status(supply_overvoltage_status),
  .external_monitor_status(external_monitor_status), .input_supply_over_flag(input_supply_over_flag));
`default_nettype wire

// >>> bench/voltage_monitor_status_flags_test.sv
// Self-checking bench for the status flag registers
`timescale 1ns/10ps
`default_nettype none
module voltage_monitor_status_flags_test import vms_pkg::*;;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] sf = 8'h00;
  logic [7:0] ef = 8'h00;
  logic en1 = 1'h0;
  logic en2 = 1'h0;
  logic cmd_valid, cmd_write, rd_valid, isf, v;
  logic [7:0] cmd_code, rd_data, sup, ext, d;
  int bad_count = 0;
  int checks = 0;
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  vms_host_model i_host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code));
  vms_status_regs i_dut (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .io_supply_over_fault(sf[7]), .input_supply_over_fault(sf[6]),
    .internal_regulator_over_fault(sf[4]), .boost_output_over_fault(sf[3]), .second_buck_over_fault(sf[1]),
    .first_buck_over_fault(sf[0]), .ext_monitor_one_over_fault(ef[1]), .ext_monitor_one_under_fault(ef[0]),
    .ext_monitor_two_over_fault(ef[5]), .ext_monitor_two_under_fault(ef[4]), .ext_monitor_one_enable(en1),
    .ext_monitor_two_enable(en2), .rd_data(rd_data), .rd_valid(rd_valid), .supply_overvoltage_status(sup),
    .external_monitor_status(ext), .input_supply_over_flag(isf));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    i_host.xfer(1'h0, c, v, d);
    chk("rd_valid", 8'h01, {7'h00, v});
    chk("rd_data", e, d);
  endtask
  task automatic t_supply;
    for (int i = 0; i < 8; i++)
    begin
      if (VMS_SUPPLY_OV_MASK[i])
      begin
        sf[i] <= 1'h1;
        cyc(4);
        sf[i] <= 1'h0;
        cyc(4);
        chk("input_flag", {7'h00, i == 6}, {7'h00, isf});
        rd(VMS_CMD_RD_SUPPLY_OV, 8'h01 << i);
        rd(VMS_CMD_RD_SUPPLY_OV, 8'h00);
      end
    end
    sf[7] <= 1'h1;
    cyc(4);
    rd(VMS_CMD_RD_SUPPLY_OV, 8'h80);
    rd(VMS_CMD_RD_SUPPLY_OV, 8'h80);
    sf[7] <= 1'h0;
    cyc(4);
    rd(VMS_CMD_RD_SUPPLY_OV, 8'h80);
    rd(VMS_CMD_RD_SUPPLY_OV, 8'h00);
    $display("test supply done");
  endtask
  task automatic t_ext_write;
    ef <= VMS_EXT_MON_MASK;
    cyc(5);
    rd(VMS_CMD_RD_EXT_MON, 8'h00);
    en1 <= 1'h1;
    en2 <= 1'h1;
    cyc(2);
    ef <= 8'h00;
    cyc(4);
    i_host.xfer(1'h1, VMS_CMD_RD_EXT_MON, v, d);
    chk("write_valid", 8'h00, {7'h00, v});
    i_host.xfer(1'h0, 8'hFF, v, d);
    chk("unknown_valid", 8'h00, {7'h00, v});
    chk("ext_port", 8'h33, ext);
    rd(VMS_CMD_RD_EXT_MON, 8'h33);
    rd(VMS_CMD_RD_EXT_MON, 8'h00);
    $display("test external and write done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic t_reset;
    resetn <= 1'h0;
    cyc(5);
    resetn <= 1'h1;
    cyc(1);
    chk("supply_port", 8'h00, sup);
    chk("ext_port", 8'h00, ext);
    rd(VMS_CMD_RD_EXT_MON, 8'h00);
    rd(VMS_CMD_RD_SUPPLY_OV, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_reset_mid;
    sf[7] <= 1'h1;
    cyc(4);
    chk("supply_port", 8'h80, sup);
    sf[7] <= 1'h0;
    t_reset;
    $display("test mid-run reset done");
  endtask
  initial
  begin
    t_reset;
    t_supply;
    t_ext_write;
    t_reset_mid;
    tally_and_finish;
  end
  // Whole run needs under 400 cycles
  initial
  begin
    #20000;
    bad_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// >>> core/vms_pkg.sv
// Constants shared by the voltage monitor status flag registers
package vms_pkg;

  // Register width
  localparam int VMS_REG_W = 8;

  // Serial command codes that select a status register
  localparam logic [7:0] VMS_CMD_RD_SUPPLY_OV = 8'h1A;
  localparam logic [7:0] VMS_CMD_RD_EXT_MON = 8'h1C;

  // Supply overvoltage register field positions
  localparam int VMS_IO_SUPPLY_OV_BIT = 7;
  localparam int VMS_INPUT_SUPPLY_OV_BIT = 6;
  localparam int VMS_REGULATOR_OV_BIT = 4;
  localparam int VMS_BOOST_OUTPUT_OVER_FLAG_BIT = 3;
  localparam int VMS_SECOND_BUCK_OVER_FLAG_BIT = 1;
  localparam int VMS_FIRST_BUCK_OVER_FLAG_BIT = 0;

  // External monitor register field positions
  localparam int VMS_EXT2_OV_BIT = 5;
  localparam int VMS_EXT2_UV_BIT = 4;
  localparam int VMS_EXT1_OV_BIT = 1;
  localparam int VMS_EXT1_UV_BIT = 0;

  // Implemented flag bits; the rest are reserved and read zero
  localparam logic [7:0] VMS_SUPPLY_OV_MASK = 8'hDB;
  localparam logic [7:0] VMS_EXT_MON_MASK = 8'h33;

  // Reset values
  localparam logic [7:0] VMS_SUPPLY_OV_RST = 8'h00;
  localparam logic [7:0] VMS_EXT_MON_RST = 8'h00;
  localparam logic [7:0] VMS_RD_DATA_RST = 8'h00;

  // Synchroniser depth for fault levels from the analog monitors
  localparam int VMS_SYNC_STAGES = 2;

endpackage

// >>> core/vms_status_regs.sv
// Latched overvoltage and undervoltage status flag registers
//
// Summary of operation
// - Each flag goes to one when its fault is seen and stays there until its register is read.
// - A read returns the current flags and then clears each set flag whose fault has gone.
// - All flags and reserved bits are zero after power-on reset, and reads update the registers.
// - Supply register bit 7 is the I/O supply overvoltage and bit 6 the input supply overvoltage.
// - Supply register bits 4, 3, 1, 0 are regulator, boost, second and first buck; bits 5 and 2 read zero.
// - The input supply overvoltage flag always equals the off-state latched input overvoltage bit.
// - An overvoltage flag reads one for a fault detected and zero for none.
// - External register bits 5 and 4 are monitor two over and under; bits 7 to 6 read zero.
// - External register bits 1 and 0 are monitor one over and under; bits 3 to 2 read zero.
// - An undervoltage flag reads one for a fault detected and zero for none.
// - A disabled external monitor has its detection masked so its flags cannot set.
`timescale 1ns/10ps
`default_nettype none

module vms_status_regs
  import vms_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  // Command from the serial interface decoder, same clock
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  // Asynchronous fault levels from the analog monitors
  input wire logic io_supply_over_fault,
  input wire logic input_supply_over_fault,
  input wire logic internal_regulator_over_fault,
  input wire logic boost_output_over_fault,
  input wire logic second_buck_over_fault,
  input wire logic first_buck_over_fault,
  input wire logic ext_monitor_one_over_fault,
  input wire logic ext_monitor_one_under_fault,
  input wire logic ext_monitor_two_over_fault,
  input wire logic ext_monitor_two_under_fault,
  // Monitor enables from the control registers, same clock
  input wire logic ext_monitor_one_enable,
  input wire logic ext_monitor_two_enable,
  // Read answer
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Flag contents, for the fault-reaction logic
  output logic [7:0] supply_overvoltage_status,
  output logic [7:0] external_monitor_status,
  // Shared with the off-state latched status register
  output logic input_supply_over_flag
);

  localparam int FAULT_W = 10;

  logic [FAULT_W-1:0] fault_async;
  logic [FAULT_W-1:0] fault_sync;

  logic [7:0] supply_fault_now;
  logic [7:0] ext_fault_now;
  logic [7:0] ext_enable_mask;
  logic rd_supply;
  logic rd_ext;

  logic [7:0] supply_r;
  logic [7:0] supply_nxt;
  logic [7:0] ext_r;
  logic [7:0] ext_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;

  assign fault_async = {ext_monitor_two_under_fault, ext_monitor_two_over_fault,
                        ext_monitor_one_under_fault, ext_monitor_one_over_fault,
                        first_buck_over_fault, second_buck_over_fault,
                        boost_output_over_fault, internal_regulator_over_fault,
                        input_supply_over_fault, io_supply_over_fault};

  vms_sync #(
    .WIDTH(FAULT_W)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(fault_async),
    .sync_out(fault_sync)
  );

  // Place synchronised faults at their register positions
  always_comb
  begin
    supply_fault_now = 8'h00;
    supply_fault_now[VMS_IO_SUPPLY_OV_BIT] = fault_sync[0];
    supply_fault_now[VMS_INPUT_SUPPLY_OV_BIT] = fault_sync[1];
    supply_fault_now[VMS_REGULATOR_OV_BIT] = fault_sync[2];
    supply_fault_now[VMS_BOOST_OUTPUT_OVER_FLAG_BIT] = fault_sync[3];
    supply_fault_now[VMS_SECOND_BUCK_OVER_FLAG_BIT] = fault_sync[4];
    supply_fault_now[VMS_FIRST_BUCK_OVER_FLAG_BIT] = fault_sync[5];
  end

  // A disabled monitor cannot raise a flag; one already latched stays
  // until the next read of its register clears it.
  always_comb
  begin
    ext_enable_mask = 8'h00;
    ext_enable_mask[VMS_EXT1_OV_BIT] = ext_monitor_one_enable;
    ext_enable_mask[VMS_EXT1_UV_BIT] = ext_monitor_one_enable;
    ext_enable_mask[VMS_EXT2_OV_BIT] = ext_monitor_two_enable;
    ext_enable_mask[VMS_EXT2_UV_BIT] = ext_monitor_two_enable;
  end

  always_comb
  begin
    ext_fault_now = 8'h00;
    ext_fault_now[VMS_EXT1_OV_BIT] = fault_sync[6];
    ext_fault_now[VMS_EXT1_UV_BIT] = fault_sync[7];
    ext_fault_now[VMS_EXT2_OV_BIT] = fault_sync[8];
    ext_fault_now[VMS_EXT2_UV_BIT] = fault_sync[9];
    ext_fault_now = ext_fault_now & ext_enable_mask;
  end

  // Writes never match a read, so they leave the flags alone
  always_comb
  begin
    rd_supply = cmd_valid && !cmd_write && (cmd_code == VMS_CMD_RD_SUPPLY_OV);
    rd_ext = cmd_valid && !cmd_write && (cmd_code == VMS_CMD_RD_EXT_MON);
  end

  // Flag update, one latch per bit: a read keeps only faults still
  // present, and a fault seen in the read cycle keeps its flag, so no
  // event is lost to the clear. Reserved positions stay at zero.
  genvar gb;
  generate
    for (gb = 0; gb < VMS_REG_W; gb++)
    begin : g_flag
      always_comb
      begin
        if (!VMS_SUPPLY_OV_MASK[gb])
        begin
          supply_nxt[gb] = 1'b0;
        end
        else if (rd_supply)
        begin
          supply_nxt[gb] = supply_fault_now[gb];
        end
        else
        begin
          supply_nxt[gb] = supply_r[gb] | supply_fault_now[gb];
        end
      end

      always_comb
      begin
        if (!VMS_EXT_MON_MASK[gb])
        begin
          ext_nxt[gb] = 1'b0;
        end
        else if (rd_ext)
        begin
          ext_nxt[gb] = ext_fault_now[gb];
        end
        else
        begin
          ext_nxt[gb] = ext_r[gb] | ext_fault_now[gb];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      supply_r <= VMS_SUPPLY_OV_RST;
      ext_r <= VMS_EXT_MON_RST;
    end
    else
    begin
      supply_r <= supply_nxt;
      ext_r <= ext_nxt;
    end
  end

  // Answer carries the contents before the clearing takes effect
  always_comb
  begin
    rd_valid_nxt = rd_supply | rd_ext;
    if (rd_supply)
    begin
      rd_data_nxt = supply_r;
    end
    else if (rd_ext)
    begin
      rd_data_nxt = ext_r;
    end
    else
    begin
      rd_data_nxt = rd_data_r;
    end
  end

  // Answer holds its last value between reads
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data_r <= VMS_RD_DATA_RST;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign supply_overvoltage_status = supply_r;
  assign external_monitor_status = ext_r;
  // One flop serves both registers, so they cannot disagree
  assign input_supply_over_flag = supply_r[VMS_INPUT_SUPPLY_OV_BIT];

endmodule

`default_nettype wire

// >>> core/vms_sync.sv
// Two-stage synchroniser bank for asynchronous fault levels
`timescale 1ns/10ps
`default_nettype none

module vms_sync
  import vms_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] stable_r;
  logic [WIDTH-1:0] stable_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      // First stage feeds only the second stage
      always_comb
      begin
        meta_nxt[gi] = async_in[gi];
        stable_nxt[gi] = meta_r[gi];
      end

      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          meta_r[gi] <= 1'b0;
          stable_r[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi] <= meta_nxt[gi];
          stable_r[gi] <= stable_nxt[gi];
        end
      end
    end
  endgenerate

  assign sync_out = stable_r;

endmodule

`default_nettype wire
